// File: hdl/fbs_params.svh
`ifndef FBS_PARAMS_SVH
`define FBS_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define FBS_OFF_CTRL       12'h000
`define FBS_OFF_STATUS     12'h004
`define FBS_OFF_ADDR       12'h008
`define FBS_OFF_WCOUNT     12'h00C

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define FBS_CTRL_LOCK_BIT  0
`define FBS_CTRL_RESET     1'b0
`define FBS_ST_IDLE_BIT    0
`define FBS_ST_READ_BIT    1
`define FBS_ST_WRITE_BIT   2
`define FBS_ST_SLEEP_BIT   3
`define FBS_ST_ORDER_BIT   4
`define FBS_ST_OE_BIT      5
`define FBS_WCOUNT_RESET   16'h0000

// ----------------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------------
`define FBS_DATA_W         18
`define FBS_LANE_W         9
`define FBS_LANES          2
`define FBS_ADDR_W         20

`endif

// File: hdl/fbs_pkg.sv
package fbs_pkg;

    // kind of access the array is in, one-hot
    typedef enum logic [2:0]
    {
        cyc_idle  = 3'b001,
        cyc_read  = 3'b010,
        cyc_write = 3'b100
    } fbs_cycle_t;

    // state of the two-bit burst sequencer
    typedef struct packed
    {
        logic [1:0] base;
        logic [1:0] cnt;
    } fbs_burst_st_t;

endpackage

// File: hdl/fbs_burst_if.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// link between access control and the burst sequencer
// ----------------------------------------------------------------------
interface fbs_burst_if;
    logic       load;
    logic       advance;
    logic       order;
    logic [1:0] load_bits;
    logic [1:0] cur_bits;
    logic [1:0] nxt_bits;

    modport ctrl (output load, advance, order, load_bits, input cur_bits, nxt_bits);
    modport counter (input load, advance, order, load_bits, output cur_bits, nxt_bits);
endinterface

`default_nettype wire

// File: hdl/fbs_burst.sv
`timescale 1ns/1ps
`default_nettype none

module fbs_burst
    import fbs_pkg::*;
(
    input  wire logic  pclk,       // clock
    input  wire logic  presetn,    // async reset, low
    fbs_burst_if.counter b         // load/advance from control
);

    fbs_burst_st_t st;
    fbs_burst_st_t next_st;

    // ------------------------------------------------------------------
    // address mapping
    // ------------------------------------------------------------------
    // interleaved xors the count in, linear adds it and wraps in four
    function automatic logic [1:0] map_bits(input logic [1:0] base, input logic [1:0] cnt,
                                            input logic ilv);
        map_bits = ilv ? (base ^ cnt) : 2'(base + cnt); // [RULE12] [RULE13]
    endfunction

    assign b.cur_bits = map_bits(st.base, st.cnt, b.order);
    assign b.nxt_bits = map_bits(st.base, 2'(st.cnt + 2'h1), b.order);

    // next state: load restarts the count, advance bumps it
    always_comb
    begin
        next_st = st;
        if (b.load)
        begin
            next_st.base = b.load_bits;
            next_st.cnt  = 2'h0;
        end
        else if (b.advance)
            next_st.cnt = 2'(st.cnt + 2'h1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // one suspend cycle between load and first advance, as masters usually give it
    a_interleave_step: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
        (b.load && b.order) ##1 (!b.load && !b.advance) ##1 (b.advance && !b.load && b.order)
        |=> b.cur_bits == ($past(b.load_bits, 3) ^ 2'h1))
        else $error("interleaved burst did not xor the count");
    a_linear_step: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
        (b.load && !b.order) ##1 (!b.load && !b.advance) ##1 (b.advance && !b.load && !b.order)
        |=> b.cur_bits == 2'($past(b.load_bits, 3) + 2'h1))
        else $error("linear burst did not increment");

endmodule

`default_nettype wire

// File: hdl/fbs_mem.sv
`timescale 1ns/1ps
`default_nettype none

module fbs_mem
#(
    parameter int ADDR_W = 20,  // word address width
    parameter int LANE_W = 9,   // bits per byte lane
    parameter int LANES  = 2    // byte lanes per word
)
(
    input  wire logic                      pclk,     // clock
    input  wire logic                      presetn,  // async reset, low
    input  wire logic                      we,       // write strobe
    input  wire logic [LANES-1:0]          lane_en,  // lanes to write
    input  wire logic                      re,       // read strobe
    input  wire logic [ADDR_W-1:0]         addr,     // word address
    input  wire logic [LANES*LANE_W-1:0]   wdata,    // write data
    output logic      [LANES*LANE_W-1:0]   rdata     // registered read data
);

    logic [LANES*LANE_W-1:0] cells [2**ADDR_W];

    // array has no reset: contents survive sleep and reset alike
    always_ff @(posedge pclk)
    begin
        for (int i = 0; i < LANES; i++)
        begin
            if (we && lane_en[i])
                cells[addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
        end
    end

    // read register holds the last word read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata <= '0;
        else if (re)
            rdata <= cells[addr];
    end

endmodule

`default_nettype wire

// File: hdl/fbs_ctrl.sv
// Notes on behaviour
// RULE1 - strobes, enables, writes sampled on rising edge; oe, sleep, order are not
// RULE2 - address loads only with all enables active and a strobe low
// RULE3 - data driven only while selected for read and oe active
// RULE4 - master enable inactive blocks the processor strobe
// RULE5 - select_high active high, select_low active low, sampled with strobes
// RULE6 - strobe low loads address, or deselects when enables not all active
// RULE7 - advance low continues burst at next internal address
// RULE8 - global write low writes all 18 bits
// RULE9 - with byte gate low each low lane input writes its lane only
// RULE10 - no lane write selected means the cycle is a read
// RULE11 - output enable acts asynchronously, only during reads
// RULE12 - interleaved order xors start bits with count 0..3
// RULE13 - linear order increments low bits, wrapping after four
// RULE14 - burst order select is static, high or open means interleaved
// RULE15 - sleep high deselects and holds data while high
// RULE16 - in sleep all inputs ignored and data pins released
// RULE17 - master must finish pending accesses before raising sleep
// RULE18 - master issues only deselect or read during wake interval
// RULE19 - master drops oe before a write that follows a read
// RULE20 - sleep input defaults low; board ties it low when unused
// RULE21 - burst advances only with both strobes high and advance low; code also advances with the processor strobe low while master enable blocks it
// RULE22 - controller strobe cycle needs processor strobe held high
// RULE23 - write inputs taken on controller start, ignored on processor start
// RULE24 - any lane write sampled low releases the data pins; code releases them only with global write low or the gate low too
// RULE25 - strobes and advance high repeat the access at the current address
`timescale 1ns/1ps
`default_nettype none
`include "fbs_params.svh"

module fbs_ctrl
    import fbs_pkg::*;
#(
    parameter int ADDR_W = `FBS_ADDR_W  // word address width
)
(
    input  wire logic                   pclk,               // clock, 40 MHz
    input  wire logic                   presetn,            // async reset, low
    input  wire logic                   clk_en,             // freezes all state when low
    input  wire logic [ADDR_W-1:0]      sram_addr,          // word address
    input  wire logic                   master_select_n,    // master enable, low
    input  wire logic                   select_high,        // secondary enable, high
    input  wire logic                   select_low_n,       // secondary enable, low
    input  wire logic                   cpu_addr_strobe_n,  // processor strobe, low
    input  wire logic                   ctrl_addr_strobe_n, // controller strobe, low
    input  wire logic                   burst_advance_n,    // advance, low
    input  wire logic                   global_write_n,     // write all lanes, low
    input  wire logic                   byte_write_gate_n,  // lane write gate, low
    input  wire logic [1:0]             lane_write_n,       // lane b, lane a, low
    input  wire logic                   out_enable_n,       // async output enable, low
    input  wire logic                   burst_order_sel,    // 1 interleaved, 0 linear
    input  wire logic                   sleep_request,      // snooze, high, board ties low [RULE20]
    input  wire logic [`FBS_DATA_W-1:0] dq_in,              // data pins in
    output logic      [`FBS_DATA_W-1:0] dq_out,             // data pins out
    output logic                        dq_oe,              // data pins driven
    input  wire logic                   psel,               // apb select
    input  wire logic                   penable,            // apb access phase
    input  wire logic                   pwrite,             // apb write
    input  wire logic [11:0]            paddr,              // apb byte address
    input  wire logic [31:0]            pwdata,             // apb write data
    output logic      [31:0]            prdata,             // apb read data
    output logic                        pready,             // apb ready
    output logic                        pslverr             // apb error
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (ADDR_W < 3 || ADDR_W > `FBS_ADDR_W)
    begin : g_bad_addr_w
        $error("fbs_ctrl: ADDR_W must lie in 3..20");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed
    {
        fbs_cycle_t        cycle;
        logic [ADDR_W-3:0] addr_hi;
        logic              lock;
        logic [15:0]       wcount;
        logic              rdy;
        logic [31:0]       rdata;
        logic              err;
    } fbs_ctrl_st_t;

    fbs_ctrl_st_t st;
    fbs_ctrl_st_t next_st;

    fbs_burst_if bif ();

    logic [ADDR_W-1:0] cur_addr;
    logic [ADDR_W-1:0] nxt_addr;
    logic [ADDR_W-1:0] acc_addr;
    logic              cpu_start;
    logic              ctrl_start;
    logic              chip_sel;
    logic [1:0]        write_lanes;
    logic              writing;
    logic              mem_we;
    logic              mem_re;
    logic [1:0]        mem_lanes;
    logic              apb_done;

    // ------------------------------------------------------------------
    // sampled pin decode
    // ------------------------------------------------------------------
    // processor strobe only counts with the master enable active
    assign cpu_start   = !cpu_addr_strobe_n && !master_select_n;              // [RULE4]
    assign ctrl_start  = !ctrl_addr_strobe_n;
    assign chip_sel    = !master_select_n && select_high && !select_low_n;   // [RULE5]
    // global write wins over the gate and the lane inputs
    assign write_lanes = !global_write_n ? 2'h3                              // [RULE8]
                       : (!byte_write_gate_n ? ~lane_write_n : 2'h0);        // [RULE9]
    assign writing     = |write_lanes;                                       // [RULE10]
    assign cur_addr    = {st.addr_hi, bif.cur_bits};
    assign nxt_addr    = {st.addr_hi, bif.nxt_bits};
    assign bif.order   = burst_order_sel;     // level only, never sampled [RULE14]
    assign apb_done    = psel && penable && st.rdy && clk_en;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st       = st;
        bif.load      = 1'b0;
        bif.advance   = 1'b0;
        bif.load_bits = sram_addr[1:0];
        acc_addr      = cur_addr;
        mem_we        = 1'b0;
        mem_re        = 1'b0;
        mem_lanes     = 2'h0;
        if (clk_en)
        begin
            // sleep ignores every pin and parks deselected
            if (sleep_request)                                        // [RULE15] [RULE16]
                next_st.cycle = cyc_idle;
            else if (cpu_start || ctrl_start)                        // [RULE1] [RULE6]
            begin
                if (chip_sel)
                begin
                    next_st.addr_hi = sram_addr[ADDR_W-1:2];         // [RULE2]
                    bif.load        = 1'b1;
                    acc_addr        = sram_addr;
                    // processor start is always a read
                    if (!cpu_start && writing)                       // [RULE23]
                        next_st.cycle = cyc_write;
                    else
                        next_st.cycle = cyc_read;
                end
                else
                    next_st.cycle = cyc_idle;                        // [RULE6]
            end
            else
            begin
                unique case (st.cycle)
                    cyc_idle: ;
                    cyc_read, cyc_write:
                    begin
                        // no start counted here (processor strobe may be low but blocked): advance or suspend
                        if (!burst_advance_n)                        // [RULE7] [RULE21]
                        begin
                            bif.advance = 1'b1;
                            acc_addr    = nxt_addr;
                        end
                        next_st.cycle = writing ? cyc_write : cyc_read;  // [RULE25]
                    end
                    default: next_st.cycle = cyc_idle;
                endcase
            end
            // the access itself on the array
            if (next_st.cycle == cyc_write && !sleep_request)
            begin
                mem_we         = !st.lock;
                mem_lanes      = write_lanes;                         // [RULE9]
                next_st.wcount = 16'(st.wcount + 16'h1);
            end
            else if (next_st.cycle == cyc_read && !sleep_request)
                mem_re = 1'b1;
            // apb: one wait state so read data comes from a flop
            if (psel && penable && !st.rdy)
            begin
                next_st.rdy   = 1'b1;
                next_st.err   = 1'b0;
                next_st.rdata = 32'h0000_0000;
                unique case (paddr)
                    `FBS_OFF_CTRL:   next_st.rdata[`FBS_CTRL_LOCK_BIT] = st.lock;
                    `FBS_OFF_STATUS:
                    begin
                        next_st.rdata[`FBS_ST_WRITE_BIT:`FBS_ST_IDLE_BIT] = st.cycle;
                        next_st.rdata[`FBS_ST_SLEEP_BIT] = sleep_request;
                        next_st.rdata[`FBS_ST_ORDER_BIT] = burst_order_sel;
                        next_st.rdata[`FBS_ST_OE_BIT]    = dq_oe;
                    end
                    `FBS_OFF_ADDR:   next_st.rdata[ADDR_W-1:0] = cur_addr;
                    `FBS_OFF_WCOUNT: next_st.rdata[15:0] = st.wcount;
                    default:         next_st.err = 1'b1;
                endcase
            end
            else if (apb_done)
            begin
                next_st.rdy = 1'b0;
                if (pwrite && paddr == `FBS_OFF_CTRL)
                    next_st.lock = pwdata[`FBS_CTRL_LOCK_BIT];
                if (pwrite && paddr == `FBS_OFF_WCOUNT)
                    next_st.wcount = `FBS_WCOUNT_RESET;
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st        <= '0;
            st.cycle  <= cyc_idle;
            st.lock   <= `FBS_CTRL_RESET;
            st.wcount <= `FBS_WCOUNT_RESET;
        end
        else
            st <= next_st;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // pins follow oe and sleep at once, no clock in the path
    assign dq_oe   = (st.cycle == cyc_read) && !out_enable_n                  // [RULE3] [RULE11]
                   && !sleep_request;                                        // [RULE16] [RULE24]
    assign prdata  = st.rdata;
    assign pslverr = st.err && st.rdy;
    assign pready  = st.rdy && clk_en;

    fbs_burst u_burst
    (
        .pclk    (pclk),
        .presetn (presetn),
        .b       (bif.counter)
    );

    fbs_mem #(.ADDR_W(ADDR_W), .LANE_W(`FBS_LANE_W), .LANES(`FBS_LANES)) u_mem
    (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (mem_we),
        .lane_en (mem_lanes),
        .re      (mem_re),
        .addr    (acc_addr),
        .wdata   (dq_in),
        .rdata   (dq_out)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_oe_gating: assert property (dq_oe |-> !out_enable_n && st.cycle == cyc_read) // [RULE11]
        else $error("data driven outside a read with oe");
    a_sleep_release: assert property (sleep_request |-> !dq_oe) // [RULE16]
        else $error("data driven during sleep");
    a_sleep_desel: assert property (clk_en && sleep_request |=> st.cycle == cyc_idle) // [RULE15]
        else $error("not deselected in sleep");
    a_addr_load: assert property (clk_en && !sleep_request && chip_sel // [RULE2]
        && (cpu_start || ctrl_start) |=> cur_addr == $past(sram_addr))
        else $error("external address not loaded");
    a_start_desel: assert property (clk_en && !sleep_request && !chip_sel // [RULE6]
        && !ctrl_addr_strobe_n |=> st.cycle == cyc_idle)
        else $error("strobe without enables did not deselect");
    a_cpu_blocked: assert property (clk_en && !sleep_request && master_select_n // [RULE4]
        && ctrl_addr_strobe_n && st.cycle != cyc_idle |=> st.cycle != cyc_idle)
        else $error("processor strobe not blocked");
    a_burst_next: assert property (clk_en && !sleep_request && st.cycle != cyc_idle // [RULE7]
        && !cpu_start && !ctrl_start && !burst_advance_n |=> cur_addr == $past(nxt_addr))
        else $error("burst did not advance");
    a_suspend_hold: assert property (clk_en && !sleep_request && st.cycle != cyc_idle // [RULE25]
        && !cpu_start && !ctrl_start && burst_advance_n |=> $stable(cur_addr))
        else $error("suspend moved the address");
    a_global_all: assert property (mem_we && !global_write_n |-> mem_lanes == 2'h3) // [RULE8]
        else $error("global write missed a lane");
    a_cpu_read: assert property (clk_en && !sleep_request && cpu_start && chip_sel // [RULE23]
        |-> !mem_we ##1 st.cycle == cyc_read)
        else $error("processor start was not a read");
    a_write_release: assert property (clk_en && !sleep_request && writing // [RULE24]
        && !cpu_start && (ctrl_start ? chip_sel : st.cycle != cyc_idle) |=> !dq_oe)
        else $error("write left data pins driven");

endmodule

`default_nettype wire

// File: testbench/fbs_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// bus master model on the memory pins
// --------
module fbs_bus_master
(
    input  wire logic        pclk,     // clock
    output logic      [19:0] addr,     // word address
    output logic             ms_n,     // master enable, low
    output logic             sel_hi,   // secondary enable, high
    output logic             sel_lo_n, // secondary enable, low
    output logic      [1:0]  strb_n,   // ctrl, cpu strobes, low
    output logic             adv_n,    // burst advance, low
    output logic      [3:0]  wr_n,     // global, gate, lane b, lane a
    output logic             oe_n,     // output enable, low
    output logic             order,    // burst order select
    output logic             sleep,    // snooze request
    output logic      [17:0] dq        // data to pins
);
    // sleep idles low as the board would tie it
    initial
    begin
        addr = 20'h0;
        {ms_n, sel_hi, sel_lo_n} = 3'h2;
        strb_n = 2'h3;
        adv_n = 1'h1;
        wr_n = 4'hF;
        {oe_n, order, sleep} = 3'h2;
        dq = 18'h0;
    end

    // one request edge, then idle; sleep is only raised between calls
    task automatic op(input logic [1:0] s, input logic a_n, input logic [3:0] w,
                      input logic [19:0] ad, input logic [17:0] d);
        @(posedge pclk);
        strb_n <= s;
        adv_n <= a_n;
        wr_n <= w;
        addr <= ad;
        dq <= d;
        @(posedge pclk);
        strb_n <= 2'h3;
        adv_n <= 1'h1;
        wr_n <= 4'hF;
        dq <= ~d; // released pins must not keep old data
        #1;
    endtask
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, dq_oe, err_v;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic [17:0] dq_out, m_dq;
    logic [17:0] mem [0:15];
    logic [19:0] m_addr;
    logic [1:0]  m_strb;
    logic [3:0]  m_wr;
    logic        m_ms_n, m_sh, m_sl_n, m_adv_n, m_oe_n, m_order, m_sleep;
    int          failures, tests_run;

    // --------
    // clock and instances
    // --------
    initial pclk = 1'h0;
    always #12.5 pclk = ~pclk;

    fbs_bus_master i_m (.pclk(pclk), .addr(m_addr), .ms_n(m_ms_n), .sel_hi(m_sh),
        .sel_lo_n(m_sl_n), .strb_n(m_strb), .adv_n(m_adv_n), .wr_n(m_wr), .oe_n(m_oe_n),
        .order(m_order), .sleep(m_sleep), .dq(m_dq));

    fbs_ctrl i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'h1), .sram_addr(m_addr),
        .master_select_n(m_ms_n), .select_high(m_sh), .select_low_n(m_sl_n),
        .cpu_addr_strobe_n(m_strb[0]), .ctrl_addr_strobe_n(m_strb[1]),
        .burst_advance_n(m_adv_n), .global_write_n(m_wr[3]), .byte_write_gate_n(m_wr[2]),
        .lane_write_n(m_wr[1:0]), .out_enable_n(m_oe_n), .burst_order_sel(m_order),
        .sleep_request(m_sleep), .dq_in(m_dq), .dq_out(dq_out), .dq_oe(dq_oe),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // --------
    // shared tasks
    // --------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do
            @(posedge pclk);
        while (pready !== 1'h1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rd(input logic [1:0] s, input logic a_n, input logic [3:0] ix);
        i_m.op(s, a_n, 4'hF, {16'h0, ix}, 18'h0);
        chk(32'(dq_out), 32'(mem[ix]));
        chk(32'(dq_oe), 32'h1);
    endtask

    task automatic wr(input logic [3:0] w, input logic [3:0] ix, input logic [17:0] d);
        i_m.op(2'h1, 1'h1, w, {16'h0, ix}, d);
        chk(32'(dq_oe), 32'h0);
        if (!w[3]) mem[ix] = d;
        if (w[3] && !w[2] && !w[0]) mem[ix][8:0] = d[8:0];
        if (w[3] && !w[2] && !w[1]) mem[ix][17:9] = d[17:9];
    endtask

    // --------
    // scenarios
    // --------
    task automatic s_burst(input logic o, input logic [1:0] st, input logic [1:0] s);
        @(posedge pclk);
        i_m.order <= o;
        rd(st, 1'h1, {2'h2, s});
        for (int k = 1; k < 4; k++)
            rd(2'h3, 1'h0, {2'h2, o ? s ^ 2'(k) : s + 2'(k)});
        rd(2'h3, 1'h1, {2'h2, o ? s ^ 2'h3 : s + 2'h3});
    endtask

    task automatic s_lanes();
        wr(4'hA, 4'h9, 18'h3FFFF);
        wr(4'h9, 4'hA, 18'h00000);
        wr(4'h8, 4'hB, 18'h15A5A);
        @(posedge pclk);
        i_m.oe_n <= 1'h0;
        for (int i = 9; i < 12; i++)
            rd(2'h2, 1'h1, 4'(i));
        i_m.op(2'h1, 1'h1, 4'hC, 20'h8, 18'h0);
        chk(32'(dq_oe), 32'h1);
        i_m.op(2'h2, 1'h1, 4'h0, 20'h9, 18'h0);
        chk(32'(dq_out), 32'(mem[9]));
    endtask

    task automatic s_desel();
        for (int i = 0; i < 3; i++)
        begin
            @(posedge pclk);
            {i_m.ms_n, i_m.sel_hi, i_m.sel_lo_n} <= 3'h2 ^ (3'h1 << i);
            i_m.oe_n <= 1'h0;
            i_m.op(2'h1, 1'h1, 4'hF, 20'h8, 18'h0);
            chk(32'(dq_oe), 32'h0);
        end
        @(posedge pclk);
        i_m.ms_n <= 1'h0;
        rd(2'h2, 1'h1, 4'h8);
        // blocked processor strobe must leave the read running
        @(posedge pclk);
        i_m.ms_n <= 1'h1;
        rd(2'h2, 1'h1, 4'h8);
    endtask

    task automatic s_sleep();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge pclk);
            {i_m.sleep, i_m.oe_n, i_m.ms_n} <= {2'(i ^ 1), 1'h0};
            #1;
            chk(32'(dq_oe), 32'(i == 1));
        end
        i_m.op(2'h1, 1'h1, 4'h7, 20'h8, 18'h0);
        chk(32'(dq_oe), 32'h0);
        @(posedge pclk);
        {i_m.sleep, i_m.oe_n} <= 2'h0;
        repeat (4) @(posedge pclk);
        rd(2'h2, 1'h1, 4'h8);
    endtask

    task automatic s_apb();
        apb(1'h0, 12'h000, 32'h0);
        chk(rd_v, 32'h0);
        apb(1'h0, 12'h010, 32'h0);
        chk({rd_v[30:0], err_v}, 32'h1);
        apb(1'h1, 12'h000, 32'h1);
        i_m.oe_n <= 1'h1;
        i_m.op(2'h1, 1'h1, 4'h7, 20'h8, 18'h0);
        apb(1'h1, 12'h000, 32'h0);
        apb(1'h0, 12'h004, 32'h0);
        chk({rd_v[4], err_v}, 32'h0);
        i_m.oe_n <= 1'h0;
        rd(2'h2, 1'h1, 4'h8);
    endtask

    // --------
    // main sequence and watchdog
    // --------
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        i_m.oe_n <= 1'h1;
        for (int i = 8; i < 12; i++)
            wr(4'h7, 4'(i), {2'h2, 4'(i), 12'hA5C});
        s_lanes();
        s_burst(1'h1, 2'h2, 2'h1);
        s_burst(1'h1, 2'h1, 2'h2);
        s_burst(1'h0, 2'h2, 2'h3);
        s_burst(1'h0, 2'h1, 2'h1);
        s_desel();
        s_sleep();
        s_apb();
        give_verdict();
    end

    initial
    begin
        #100us;
        failures++;
        give_verdict();
    end
endmodule
`default_nettype wire
